// ==== rtl/pwc_top.sv ====
module pwc_top #(
  parameter int CHANNELS = 2
) (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic [9:0] addr,
  input wire logic [15:0] wdata,
  input wire logic wr,
  input wire logic rd,
  input wire logic [1:0] short_sense,
  input wire logic supply_short,
  input wire logic [1:0] gate_input,
  output logic [15:0] rdata,
  output logic [1:0] switch_out,
  output logic diag_msg
);
  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [1:0][15:0] duty;
    logic [1:0][7:0] ctrl;
    logic [1:0][7:0] scale;
    logic [1:0][15:0] period;
    logic [1:0][15:0] min_pulse;
    logic [1:0][15:0] on_delay;
    logic [1:0][1:0] diag_en;
    logic [1:0] short_flag;
    logic [1:0] param_err;
    logic [15:0] rdata;
    logic [1:0] out;
    logic diag_msg;
  } pwc_top_s;
  pwc_top_s st_reg;
  pwc_top_s st_next;
  logic tick;
  logic [1:0] eng_out;
  logic [1:0] eng_active;
  logic [1:0] eng_done;
  logic [1:0] gate;

  pwc_tick #(
    .CYCLES(pwc_pkg::TICK_CYCLES)
  ) u_tick (
    .clk(clk),
    .reset_n(reset_n),
    .tick(tick)
  );

  // ----------------------------------------------------------------
  // Two independent engines
  // ----------------------------------------------------------------
  genvar gi;
  generate
    for (gi = 0; gi < CHANNELS; gi++) begin : g_ch
      assign gate[gi] = st_reg.ctrl[gi][pwc_pkg::CTRL_GATE_BIT]
                        & ~st_reg.param_err[gi];
      pwc_engine u_eng (
        .clk(clk),
        .reset_n(reset_n),
        .tick(tick),
        .gate(gate[gi]),
        .duty(st_reg.duty[gi]),
        .scale(st_reg.scale[gi]),
        .period(st_reg.period[gi]),
        .min_pulse(st_reg.min_pulse[gi]),
        .on_delay(st_reg.on_delay[gi]),
        .out(eng_out[gi]),
        .active(eng_active[gi]),
        .done(eng_done[gi])
      );
    end
  endgenerate

  // ----------------------------------------------------------------
  // Register access and diagnostics
  // ----------------------------------------------------------------
  always_comb begin
    logic [9:0] rel;
    logic [7:0] fb;
    logic grp;
    rel = 10'h000;
    fb = 8'h00;
    grp = 1'b0;
    st_next = st_reg;
    st_next.rdata = 16'h0000;
    for (int c = 0; c < CHANNELS; c++) begin
      rel = addr - 10'(c) * pwc_pkg::CH_STRIDE;
      if (wr) begin
        if (rel == pwc_pkg::DUTY_VALUE_WORD_OFS) begin
          st_next.duty[c] = wdata;
        end
        if (rel == pwc_pkg::CHANNEL_CONTROL_BYTE_OFS) begin
          st_next.ctrl[c] = wdata[7:0];
        end
        if (rel == pwc_pkg::PERIOD_SCALE_BYTE_OFS) begin
          st_next.scale[c] = wdata[7:0];
        end
        if (rel == pwc_pkg::PARAM_PERIOD_OFS) begin
          st_next.period[c] = wdata;
        end
        if (rel == pwc_pkg::PARAM_MIN_PULSE_OFS) begin
          st_next.min_pulse[c] = wdata;
        end
        if (rel == pwc_pkg::PARAM_ON_DELAY_OFS) begin
          st_next.on_delay[c] = wdata;
        end
        if (rel == pwc_pkg::PARAM_DIAG_OFS) begin
          st_next.diag_en[c] = wdata[1:0];
        end
      end
      // Parameter error: minimum pulse longer than half a period
      st_next.param_err[c] = ({st_next.min_pulse[c], 1'b0} >
                              {1'b0, st_next.period[c]});
      // Short flag is sticky while the output is diagnosed; gate clears
      if (st_reg.diag_en[c][pwc_pkg::DIAG_OUT_EN_BIT] && short_sense[c]
          && st_reg.out[c]) begin
        st_next.short_flag[c] = 1'b1;
      end else if (wr && rel == pwc_pkg::CHANNEL_CONTROL_BYTE_OFS
                   && !wdata[pwc_pkg::CTRL_GATE_BIT]) begin
        st_next.short_flag[c] = 1'b0;
      end
      if (st_reg.diag_en[c][pwc_pkg::DIAG_GROUP_EN_BIT] &&
          (st_reg.short_flag[c] || supply_short || st_reg.param_err[c])) begin
        grp = 1'b1;
      end
      fb = 8'h00;
      fb[pwc_pkg::FB_ACTIVE_BIT] = eng_active[c];
      fb[pwc_pkg::FB_OUT_BIT] = st_reg.out[c];
      fb[pwc_pkg::FB_SHORT_BIT] = st_reg.short_flag[c];
      fb[pwc_pkg::FB_PARAM_ERR_BIT] = st_reg.param_err[c];
      fb[pwc_pkg::FB_DIAG_BIT] = st_reg.diag_msg;
      fb[pwc_pkg::FB_SUPPLY_BIT] = supply_short;
      fb[6] = eng_done[c];
      fb[7] = gate_input[c];
      if (rd && rel == pwc_pkg::FEEDBACK_BYTE_OFS) begin
        st_next.rdata = {8'h00, fb};
      end
      // A shorted output is switched off until the gate is cleared
      st_next.out[c] = eng_out[c] & ~st_next.short_flag[c];
    end
    st_next.diag_msg = grp;
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      st_reg <= '0;
      st_reg.scale <= {pwc_pkg::SCALE_RESET, pwc_pkg::SCALE_RESET};
      st_reg.period <= {pwc_pkg::PERIOD_RESET, pwc_pkg::PERIOD_RESET};
      st_reg.min_pulse <= {pwc_pkg::MIN_PULSE_RESET,
                           pwc_pkg::MIN_PULSE_RESET};
      st_reg.diag_en <= {pwc_pkg::DIAG_RESET, pwc_pkg::DIAG_RESET};
    end else begin
      st_reg <= st_next;
    end
  end

  assign rdata = st_reg.rdata;
  assign switch_out = st_reg.out;
  assign diag_msg = st_reg.diag_msg;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  a_gate_off_low: assert property (@(posedge clk)
    disable iff (!reset_n) !gate[0] |-> ##2 !switch_out[0])
    else $error("ch0 on, gate off");
  a_fb_read_data: assert property (@(posedge clk)
    disable iff (!reset_n) (rd && addr == pwc_pkg::FEEDBACK_BYTE_OFS) |=>
    rdata[15:8] == 8'h00) else $error("feedback upper bits set");
  a_short_sticky: assert property (@(posedge clk)
    disable iff (!reset_n) (st_reg.short_flag[0] && !wr) |=>
    st_reg.short_flag[0]) else $error("short flag lost");
  a_short_kills_out: assert property (@(posedge clk)
    disable iff (!reset_n) st_reg.short_flag[0] |-> !switch_out[0])
    else $error("shorted output driven");
  a_group_diag: assert property (@(posedge clk)
    disable iff (!reset_n) (st_reg.diag_en[0][1] && supply_short) |=>
    diag_msg) else $error("no group diagnostic");
  a_ch1_gate_low: assert property (@(posedge clk)
    disable iff (!reset_n) !gate[1] |-> ##2 !switch_out[1])
    else $error("ch1 on, gate off");
  a_ch1_short_off: assert property (@(posedge clk)
    disable iff (!reset_n) st_reg.short_flag[1] |-> !switch_out[1])
    else $error("shorted ch1 output driven");
  a_rdata_idle_zero: assert property (@(posedge clk)
    disable iff (!reset_n) !rd |=> rdata == 16'h0000)
    else $error("read data outside read cycle");
  a_group_quiet: assert property (@(posedge clk)
    disable iff (!reset_n)
    (!st_reg.diag_en[0][1] && !st_reg.diag_en[1][1]) |=> !diag_msg)
    else $error("diagnostic while group disabled");
  a_fb_active_bit: assert property (@(posedge clk)
    disable iff (!reset_n) (rd && addr == pwc_pkg::FEEDBACK_BYTE_OFS) |=>
    rdata[pwc_pkg::FB_ACTIVE_BIT] == $past(eng_active[0]))
    else $error("active flag not reported");
endmodule : pwc_top

// ==== rtl/pwc_pkg.sv ====
// Package: register map, field layout and timing constants of the PWM channel
package pwc_pkg;
  // ----------------------------------------------------------------
  // Register offsets (per channel, channel 1 adds CH_STRIDE)
  // ----------------------------------------------------------------
  localparam logic [9:0] DUTY_VALUE_WORD_OFS = 10'h100;
  localparam logic [9:0] CHANNEL_CONTROL_BYTE_OFS = 10'h102;
  localparam logic [9:0] PERIOD_SCALE_BYTE_OFS = 10'h103;
  localparam logic [9:0] FEEDBACK_BYTE_OFS = 10'h100;
  localparam logic [9:0] CH_STRIDE = 10'h004;
  localparam logic [9:0] PARAM_BASE_OFS = 10'h110;
  localparam logic [9:0] PARAM_PERIOD_OFS = 10'h110;
  localparam logic [9:0] PARAM_MIN_PULSE_OFS = 10'h111;
  localparam logic [9:0] PARAM_ON_DELAY_OFS = 10'h112;
  localparam logic [9:0] PARAM_DIAG_OFS = 10'h113;
  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int CTRL_GATE_BIT = 0;
  localparam int FB_ACTIVE_BIT = 0;
  localparam int FB_OUT_BIT = 1;
  localparam int FB_SHORT_BIT = 2;
  localparam int FB_PARAM_ERR_BIT = 3;
  localparam int FB_DIAG_BIT = 4;
  localparam int FB_SUPPLY_BIT = 5;
  localparam int DIAG_OUT_EN_BIT = 0;
  localparam int DIAG_GROUP_EN_BIT = 1;
  // ----------------------------------------------------------------
  // Reset values and scaling
  // ----------------------------------------------------------------
  localparam logic [15:0] DUTY_RESET = 16'h0000;
  localparam logic [7:0] SCALE_RESET = 8'h0A;
  localparam logic [7:0] SCALE_ONE = 8'h0A;
  localparam logic [15:0] PERMILL_FULL = 16'h03E8;
  localparam logic [15:0] PERIOD_RESET = 16'h7530;
  localparam logic [15:0] MIN_PULSE_RESET = 16'h01F4;
  localparam logic [15:0] ON_DELAY_RESET = 16'h0000;
  localparam logic [1:0] DIAG_RESET = 2'h1;
  // ----------------------------------------------------------------
  // Time base
  // ----------------------------------------------------------------
  localparam int CLK_HZ = 10_000_000;
  localparam int TIME_BASE_US = 1000;
  localparam int TICK_CYCLES = CLK_HZ / 1_000_000 * TIME_BASE_US;
endpackage : pwc_pkg

// ==== rtl/pwc_tick.sv ====
// Time-base tick generator: one pulse per time-base unit
module pwc_tick #(
  parameter int CYCLES = pwc_pkg::TICK_CYCLES
) (
  input wire logic clk,
  input wire logic reset_n,
  output logic tick
);
  typedef struct packed {
    logic [23:0] cnt;
    logic tick;
  } pwc_tick_s;
  pwc_tick_s st_reg;
  pwc_tick_s st_next;

  always_comb begin
    st_next = st_reg;
    st_next.tick = 1'b0;
    if (st_reg.cnt == 24'(CYCLES - 1)) begin
      st_next.cnt = 24'h000000;
      st_next.tick = 1'b1;
    end else begin
      st_next.cnt = st_reg.cnt + 24'h000001;
    end
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign tick = st_reg.tick;
endmodule : pwc_tick

// ==== rtl/pwc_engine.sv ====
// One PWM engine: on-delay, period/duty sequencing, minimum pulse limit
module pwc_engine (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic tick,
  input wire logic gate,
  input wire logic [15:0] duty,
  input wire logic [7:0] scale,
  input wire logic [15:0] period,
  input wire logic [15:0] min_pulse,
  input wire logic [15:0] on_delay,
  output logic out,
  output logic active,
  output logic done
);
  typedef enum logic [1:0] {IDLE, DELAY, ON, OFF} pwc_eng_e;
  typedef struct packed {
    pwc_eng_e state;
    logic [31:0] cnt;
    logic [31:0] on_t;
    logic [31:0] off_t;
    logic out;
    logic done;
  } pwc_eng_s;
  pwc_eng_s st_reg;
  pwc_eng_s st_next;
  logic [31:0] eff_period;
  logic [31:0] on_raw;
  logic [31:0] on_lim;
  logic [31:0] off_lim;
  logic [15:0] duty_c;

  // Effective period in units; on-time by per mill share
  always_comb begin
    duty_c = (duty > pwc_pkg::PERMILL_FULL) ? pwc_pkg::PERMILL_FULL
                                            : duty;
    eff_period = 32'(({16'h0000, period} * {24'h000000, scale})
                     / {24'h000000, pwc_pkg::SCALE_ONE});
    on_raw = 32'((64'(eff_period) * 64'(duty_c))
                 / 64'(pwc_pkg::PERMILL_FULL));
    // Shares too short for the switching element collapse to 0 or full
    on_lim = on_raw;
    if (on_raw != 32'h0 && on_raw < {16'h0000, min_pulse}) begin
      on_lim = 32'h0;
    end
    off_lim = eff_period - on_lim;
    if (off_lim != 32'h0 && off_lim < {16'h0000, min_pulse}) begin
      // Full on; a period shorter than the minimum still holds one
      // minimum pulse before the share is looked at again
      on_lim = (eff_period < {16'h0000, min_pulse}) ?
               {16'h0000, min_pulse} : eff_period;
      off_lim = 32'h0;
    end
  end

  always_comb begin
    st_next = st_reg;
    if (!gate) begin
      st_next.state = IDLE;
      st_next.out = 1'b0;
      st_next.done = st_reg.state != IDLE ? 1'b1 : st_reg.done;
    end else begin
      case (st_reg.state)
        IDLE: begin
          st_next.done = 1'b0;
          st_next.cnt = 32'h0;
          if (on_delay == 16'h0000) begin
            st_next.state = OFF;
            st_next.off_t = 32'h0;
          end else begin
            st_next.state = DELAY;
          end
        end
        DELAY: begin
          if (tick) begin
            st_next.cnt = st_reg.cnt + 32'h1;
            if (st_reg.cnt + 32'h1 >= {16'h0000, on_delay}) begin
              st_next.state = OFF;
              st_next.off_t = 32'h0;
              st_next.cnt = 32'h0;
            end
          end
        end
        ON: begin
          if (tick) begin
            st_next.cnt = st_reg.cnt + 32'h1;
          end
          if ((tick ? st_reg.cnt + 32'h1 : st_reg.cnt) >= st_reg.on_t) begin
            st_next.cnt = 32'h0;
            if (st_reg.off_t != 32'h0) begin
              st_next.state = OFF;
              st_next.off_t = st_reg.off_t;
              st_next.out = 1'b0;
            end else begin
              // No off phase: chain the next period without a low glitch
              st_next.on_t = on_lim;
              st_next.off_t = off_lim;
              if (on_lim == 32'h0) begin
                st_next.state = OFF;
                st_next.out = 1'b0;
              end
            end
          end
        end
        OFF: begin
          if (tick && st_reg.cnt < st_reg.off_t) begin
            st_next.cnt = st_reg.cnt + 32'h1;
          end
          if (st_reg.cnt >= st_reg.off_t ||
              (tick && st_reg.cnt + 32'h1 >= st_reg.off_t)) begin
            // New period: latch fresh timing
            st_next.cnt = 32'h0;
            st_next.on_t = on_lim;
            st_next.off_t = off_lim;
            if (on_lim != 32'h0) begin
              st_next.state = ON;
              st_next.out = 1'b1;
            end else begin
              st_next.state = OFF;
              st_next.out = 1'b0;
            end
            if (eff_period == 32'h0) begin
              st_next.off_t = 32'h1;
            end
          end
        end
        default: begin
          st_next.state = IDLE;
          st_next.out = 1'b0;
        end
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign out = st_reg.out;
  assign active = st_reg.state != IDLE;
  assign done = st_reg.done;

  a_gate_low_out: assert property (@(posedge clk)
    disable iff (!reset_n) !gate |=> !out)
    else $error("output high after gate low");
  a_zero_delay_start: assert property (@(posedge clk)
    disable iff (!reset_n)
    (st_reg.state == IDLE && gate && on_delay == 16'h0000) |=>
    st_reg.state == OFF) else $error("no immediate start");
  a_min_on_len: assert property (@(posedge clk)
    disable iff (!reset_n)
    (st_reg.state == ON) |-> (st_reg.on_t >= {16'h0000, min_pulse} ||
    $changed(min_pulse))) else $error("on phase too short");
endmodule : pwc_engine

// ==== verification/pwc_switch_model.sv ====
// Switching element model: measures pulse phases and can report a short
module pwc_switch_model (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic drive,
  input wire logic fault_cmd,
  output logic sense_short,
  output int on_len,
  output int off_len
);
  timeunit 1ns;
  timeprecision 1ns;
  int run_len;
  logic last_drive;
  // -----------------------------------------------------------------
  // Short sensing
  // -----------------------------------------------------------------
  // Only the bench can order a short, so a fault never appears unasked
  assign sense_short = fault_cmd;
  // -----------------------------------------------------------------
  // Phase measurement
  // -----------------------------------------------------------------
  // A phase is only reported once it has ended, so partial phases at the
  // start of the train never reach a comparison
  always @(posedge clk) begin
    if (!reset_n) begin
      run_len <= 0;
      last_drive <= 1'b0;
      on_len <= 0;
      off_len <= 0;
    end else begin
      last_drive <= drive;
      if (drive !== last_drive) begin
        run_len <= 1;
        if (last_drive === 1'b1) begin
          on_len <= run_len;
        end else begin
          off_len <= run_len;
        end
      end else begin
        run_len <= run_len + 1;
      end
    end
  end
endmodule : pwc_switch_model

// ==== verification/pwm_output_channel_test.sv ====
// Self-checking bench of the PWM output channel block
module pwm_output_channel_test;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk, reset_n, wr, rd, supply_short, diag_msg, fault_cmd;
  logic [9:0] addr;
  logic [15:0] wdata, rdata;
  logic [1:0] short_sense, gate_input, switch_out;
  int on_len, off_len, miscompares, tests_run;
  logic [31:0] seed;
  logic [15:0] fb;
  logic g0;
  pwc_top dut (.clk(clk), .reset_n(reset_n), .addr(addr), .wdata(wdata),
    .wr(wr), .rd(rd), .short_sense(short_sense),
    .supply_short(supply_short), .gate_input(gate_input), .rdata(rdata),
    .switch_out(switch_out), .diag_msg(diag_msg));
  pwc_switch_model partner (.clk(clk), .reset_n(reset_n),
    .drive(switch_out[1]), .fault_cmd(fault_cmd),
    .sense_short(short_sense[1]), .on_len(), .off_len());
  pwc_switch_model meter (.clk(clk), .reset_n(reset_n),
    .drive(switch_out[0]), .fault_cmd(fault_cmd), .sense_short(short_sense[0]),
    .on_len(on_len), .off_len(off_len));
  // -----------------------------------------------------------------
  // Helpers
  // -----------------------------------------------------------------
  function automatic logic [31:0] lfsr_next(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr_next
  task automatic give_verdict;
    $display("compares %0d mismatches %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : give_verdict
  task automatic chk(input string what, input logic [31:0] exp,
    input logic [31:0] got);
    tests_run++;
    if (got !== exp) begin
      miscompares++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  task automatic wr_reg(input logic [9:0] a, input logic [15:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask : wr_reg
  // Read data stand only in the cycle after the strobe
  task automatic rd_reg(input logic [9:0] a, output logic [15:0] d);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    @(negedge clk);
    d = rdata;
  endtask : rd_reg
  function automatic logic [15:0] fb_exp(input logic g, input logic [6:0] b);
    return {8'h00, g, b};
  endfunction : fb_exp
  // -----------------------------------------------------------------
  // Clock, reset and watchdog
  // -----------------------------------------------------------------
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  initial begin
    repeat (90000) @(posedge clk);
    miscompares++;
    give_verdict();
  end
  // -----------------------------------------------------------------
  // Main sequence
  // -----------------------------------------------------------------
  initial begin
    reset_n = 1'b0;
    wr = 1'b0;
    rd = 1'b0;
    addr = 10'h000;
    wdata = 16'h0000;
    supply_short = 1'b0;
    fault_cmd = 1'b0;
    seed = 32'h7133EE2F;
    gate_input = 2'h0;
    miscompares = 0;
    tests_run = 0;
    repeat (4) @(posedge clk);
    reset_n <= 1'b1;
    @(negedge clk);
    chk("switch_out after reset", 2'h0, switch_out);
    chk("diag_msg after reset", 1'b0, diag_msg);
    seed = lfsr_next(seed);
    @(posedge clk);
    gate_input <= seed[1:0];
    g0 = seed[0];
    repeat (3) @(posedge clk);
    rd_reg(10'h100, fb);
    chk("feedback ch0", fb_exp(g0, 7'h00), fb);
    rd_reg(10'h104, fb);
    chk("feedback ch1", fb_exp(seed[1], 7'h00), fb);
    seed = lfsr_next(seed);
    wr_reg({2'b00, seed[15:8]}, seed[31:16]);
    rd_reg({2'b00, seed[7:0]}, fb);
    chk("unmapped read", 16'h0000, fb);
    // Minimum pulse too long for the period sets the parameter error
    wr_reg(10'h113, 16'h0003);
    wr_reg(10'h111, 16'h0003);
    wr_reg(10'h110, 16'h0004);
    repeat (2) @(posedge clk);
    rd_reg(10'h100, fb);
    chk("feedback param error", fb_exp(g0, 7'h18), fb);
    chk("diag_msg param error", 1'b1, diag_msg);
    wr_reg(10'h111, 16'h0001);
    @(posedge clk);
    supply_short <= 1'b1;
    repeat (3) @(posedge clk);
    rd_reg(10'h100, fb);
    chk("feedback supply short", fb_exp(g0, 7'h30), fb);
    @(posedge clk);
    supply_short <= 1'b0;
    repeat (3) @(negedge clk);
    chk("diag_msg cleared", 1'b0, diag_msg);
    // Factor 5 tenths of period 4 gives two ticks; half on, half off
    wr_reg(10'h103, 16'h0005);
    wr_reg(10'h100, 16'd500);
    wr_reg(10'h104, 16'd1000);
    wr_reg(10'h106, 16'h0001);
    wr_reg(10'h102, 16'h0001);
    repeat (35000) @(posedge clk);
    chk("on phase cycles", pwc_pkg::TICK_CYCLES, on_len);
    chk("off phase cycles", pwc_pkg::TICK_CYCLES, off_len);
    chk("full duty ch1", 1'b1, switch_out[1]);
    rd_reg(10'h100, fb);
    chk("active flag", 16'h0001, fb & 16'h0001);
    // Both outputs shorted; channel 0 trips at its next on phase
    @(posedge clk);
    fault_cmd <= 1'b1;
    repeat (3) @(negedge clk);
    chk("ch1 off on short", 1'b0, switch_out[1]);
    rd_reg(10'h104, fb);
    chk("short flag ch1", 16'h0004, fb & 16'h0004);
    repeat (20100) @(posedge clk);
    rd_reg(10'h100, fb);
    chk("short flag ch0", 16'h0004, fb & 16'h0004);
    chk("diag_msg ch0 short", 1'b1, diag_msg);
    chk("ch0 off on short", 1'b0, switch_out[0]);
    wr_reg(10'h102, 16'h0000);
    repeat (2) @(negedge clk);
    chk("ch0 off after gate", 1'b0, switch_out[0]);
    rd_reg(10'h100, fb);
    chk("done flag", 16'h0040, fb & 16'h0041);
    give_verdict();
  end
endmodule : pwm_output_channel_test
